// ===== ldo_bank_checker.sv
/* Port checker for the regulator bank.
   Assumes bind to the bank top, strobes one cycle wide. */
`timescale 1ns/1ps
module ldo_bank_checker (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire wr_en,
  input wire rd_en,
  input wire rvalid,
  input wire irq,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire [3:0] pgood_in,
  input wire [3:0] fault_in,
  input wire [3:0] chan_on,
  input wire [3:0] shutdown_pulldown_en,
  input wire [3:0] low_quiescent_mode,
  input wire [11:0] turn_on_delay,
  input wire [17:0] output_level_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_on; wr_en && ce && addr == 8'h55 |-> ##2 chan_on[1] == $past(wdata[7], 2); endproperty
  a_on: assert property (p_on) else $error("enable bit");
  property p_pd; wr_en && ce && addr == 8'h51 |-> ##2
    shutdown_pulldown_en[0] == ($past(wdata[6], 2) && !$past(wdata[7], 2)); endproperty
  a_pd: assert property (p_pd) else $error("pulldown");
  property p_lq; wr_en && ce && addr == 8'h61 |-> ##2
    low_quiescent_mode[2] == $past(wdata[5], 2); endproperty
  a_lq: assert property (p_lq) else $error("low iq");
  property p_dly; wr_en && ce && addr == 8'h65 |-> ##2
    turn_on_delay[11:9] == $past(wdata[4:2], 2); endproperty
  a_dly: assert property (p_dly) else $error("delay");
  property p_irq; (ce && fault_in == 4'h0) [*5] |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_pg; rd_en && ce && addr == 8'h51 && $past(pgood_in[0], 2) == pgood_in[0]
    && $past(pgood_in[0]) == pgood_in[0] |=> rdata[0] == $past(pgood_in[0]); endproperty
  a_pg: assert property (p_pg) else $error("power good");
  property p_lvl; wr_en && ce && addr == 8'h60 |-> ##2
    output_level_code[11:6] == $past(wdata[5:0], 2); endproperty
  a_lvl: assert property (p_lvl) else $error("level");
  property p_rsv; rd_en && ce && addr == 8'h54 |=> rvalid && rdata[7:6] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_unm; rd_en && ce && addr == 8'h70 |=> rvalid && rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  cover property (wr_en && addr == 8'h65);
  cover property (rd_en && addr == 8'h50);
  cover property (irq);
  cover property (wr_en && !ce);
endmodule
bind ldo_control_registers ldo_bank_checker ldo_bank_checker_i (.*);

// ===== ldo_bank_consts.vh
/*
  Register map, field positions and reset values for the linear
  regulator control bank. Assumes the including file is plain Verilog.
*/
`ifndef LDO_BANK_CONSTS_VH
`define LDO_BANK_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CH_A_CTRL 8'h51
`define ADDR_CH_B_LEVEL 8'h54
`define ADDR_CH_B_CTRL 8'h55
`define ADDR_CH_C_LEVEL 8'h60
`define ADDR_CH_C_CTRL 8'h61
`define ADDR_CH_D_LEVEL 8'h64
`define ADDR_CH_D_CTRL 8'h65

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_ON_BIT 7
`define CTRL_PULLDOWN_BIT 6
`define CTRL_LOW_QUIESCENT_MODE_BIT 5
`define CTRL_DELAY_HI 4
`define CTRL_DELAY_LO 2
`define CTRL_IRQEN_BIT 1
`define CTRL_PGOOD_BIT 0
`define CTRL_WR_MASK 8'hFE

// ----------------------------------------
// Level register fields
// ----------------------------------------
`define LEVEL_HI 5
`define LEVEL_MASK 8'h3F

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define CTRL_RESET 7'h00
`define LEVEL_RESET 6'h00
`define NUM_CH 4
`define READ_ZERO 8'h00
`define ADDR_NONE 8'hFF
`define CH_BUS_RESET 4'h0
`define DELAY_BUS_RESET 12'h000
`define LEVEL_BUS_RESET 18'h00000
`define LEVEL_ALL_HI 23
`define LEVEL_ALL_LO 6

`endif

// ===== ldo_channel_regs.v
/*
  One regulator channel: control and level fields, power-good
  readback, fault interrupt gating.
  Assumes synchronized power-good and fault inputs from the caller.
*/
`timescale 1ns/1ps
`include "ldo_bank_consts.vh"

module ldo_channel_regs (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire ctrl_we,
  input wire level_we,
  input wire [7:0] wdata,
  input wire pgood,
  input wire fault,
  output wire [7:0] ctrl_rd,
  output wire [7:0] level_rd,
  output wire [5:0] output_level_code,
  output wire chan_on,
  output wire shutdown_pulldown_en,
  output wire low_quiescent_mode,
  output wire [2:0] turn_on_delay,
  output wire fault_irq
);

  reg [6:0] ctrl_r;
  reg [5:0] level_r;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      ctrl_r <= `CTRL_RESET;
      level_r <= `LEVEL_RESET;
    end else if (ce) begin
      if (ctrl_we) begin
        ctrl_r <= wdata[`CTRL_ON_BIT:`CTRL_IRQEN_BIT];
      end
      if (level_we) begin
        level_r <= wdata[`LEVEL_HI:0];
      end
    end
  end

  assign chan_on = ctrl_r[`CTRL_ON_BIT-1];
  assign shutdown_pulldown_en = ctrl_r[`CTRL_PULLDOWN_BIT-1] & ~chan_on;
  assign low_quiescent_mode = ctrl_r[`CTRL_LOW_QUIESCENT_MODE_BIT-1];
  assign turn_on_delay = ctrl_r[`CTRL_DELAY_HI-1:`CTRL_DELAY_LO-1];
  assign fault_irq = fault & ctrl_r[`CTRL_IRQEN_BIT-1];
  // Power-good is never stored, so writes cannot touch it
  assign ctrl_rd = {ctrl_r, pgood};
  // Reserved upper bits read zero
  assign level_rd = {2'h0, level_r};
  assign output_level_code = level_r;

endmodule

// ===== ldo_control_registers.v
/*
  Register bank for four linear regulator channels, reached through
  an address/data port from the serial interface logic. It keeps the
  control fields of four channels and the level codes of three, and
  drives every field out as a registered level.
  Assumes clk, srst and the strobes come from that interface logic on
  the same clock, with each strobe one cycle wide; power-good and
  fault come straight from the analog side and are synchronized here.
  The host takes rdata in the cycle in which rvalid is high.
*/
`timescale 1ns/1ps
`include "ldo_bank_consts.vh"

module ldo_control_registers (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire [7:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  output reg rvalid,
  input wire [3:0] pgood_in,
  input wire [3:0] fault_in,
  output reg [3:0] chan_on,
  output reg [3:0] shutdown_pulldown_en,
  output reg [3:0] low_quiescent_mode,
  output reg [11:0] turn_on_delay,
  output reg [17:0] output_level_code,
  output reg irq
);

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  reg [3:0] pgood_s1_r;
  reg [3:0] pgood_s2_r;
  reg [3:0] fault_s1_r;
  reg [3:0] fault_s2_r;
  reg [7:0] rdata_nxt;
  wire [3:0] ctrl_we;
  wire [3:0] level_we;
  wire [31:0] ctrl_rd;
  wire [31:0] level_rd;
  wire [23:0] level_all;
  wire [3:0] on_w;
  wire [3:0] pd_w;
  wire [3:0] lq_w;
  wire [11:0] dly_w;
  wire [3:0] irq_w;
  wire [31:0] ctrl_addr;
  wire [31:0] level_addr;
  wire [3:0] ctrl_hit;
  wire [3:0] level_hit;
  wire wr_take;
  wire rd_take;
  wire irq_any;

  // ----------------------------------------
  // Pin synchronizers
  // ----------------------------------------
  // Power-good feeds only the readback, so two flops of latency are harmless
  always @(posedge clk) begin
    if (srst) begin
      pgood_s1_r <= `CH_BUS_RESET;
      pgood_s2_r <= `CH_BUS_RESET;
    end else if (ce) begin
      pgood_s1_r <= pgood_in;
      pgood_s2_r <= pgood_s1_r;
    end
  end

  // Faults take two flops here and one more in the interrupt register
  always @(posedge clk) begin
    if (srst) begin
      fault_s1_r <= `CH_BUS_RESET;
      fault_s2_r <= `CH_BUS_RESET;
    end else if (ce) begin
      fault_s1_r <= fault_in;
      fault_s2_r <= fault_s1_r;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Channel a has only its control register in this bank
  assign ctrl_addr = {`ADDR_CH_D_CTRL, `ADDR_CH_C_CTRL, `ADDR_CH_B_CTRL, `ADDR_CH_A_CTRL};
  assign level_addr = {`ADDR_CH_D_LEVEL, `ADDR_CH_C_LEVEL, `ADDR_CH_B_LEVEL, `ADDR_NONE};

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  // Strobes count only while the clock enable lets state move
  assign wr_take = wr_en & ce;
  assign rd_take = rd_en & ce;

  // ----------------------------------------
  // Channel slices
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `NUM_CH; i = i + 1) begin : g_ch
      assign ctrl_hit[i] = (addr == ctrl_addr[8*i+7:8*i]);
      // Slot a has no level register, so its hit is held low
      assign level_hit[i] = (i != 0) & (addr == level_addr[8*i+7:8*i]);
      assign ctrl_we[i] = wr_take & ctrl_hit[i];
      assign level_we[i] = wr_take & level_hit[i];
      // Slot a keeps an idle level store; cheaper than a second slice type
      ldo_channel_regs u_ch (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .ctrl_we(ctrl_we[i]),
        .level_we(level_we[i]),
        .wdata(wdata),
        .pgood(pgood_s2_r[i]),
        .fault(fault_s2_r[i]),
        .ctrl_rd(ctrl_rd[8*i+7:8*i]),
        .level_rd(level_rd[8*i+7:8*i]),
        .output_level_code(level_all[6*i+5:6*i]),
        .chan_on(on_w[i]),
        .shutdown_pulldown_en(pd_w[i]),
        .low_quiescent_mode(lq_w[i]),
        .turn_on_delay(dly_w[3*i+2:3*i]),
        .fault_irq(irq_w[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // A write in the same cycle is seen only by the next read
  always @* begin
    rdata_nxt = `READ_ZERO;
    case (addr)
      `ADDR_CH_A_CTRL: rdata_nxt = ctrl_rd[7:0];
      `ADDR_CH_B_LEVEL: rdata_nxt = level_rd[15:8];
      `ADDR_CH_B_CTRL: rdata_nxt = ctrl_rd[15:8];
      `ADDR_CH_C_LEVEL: rdata_nxt = level_rd[23:16];
      `ADDR_CH_C_CTRL: rdata_nxt = ctrl_rd[23:16];
      `ADDR_CH_D_LEVEL: rdata_nxt = level_rd[31:24];
      `ADDR_CH_D_CTRL: rdata_nxt = ctrl_rd[31:24];
      // Unmapped addresses read zero rather than hang the host
      default: rdata_nxt = `READ_ZERO;
    endcase
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // rdata holds the last read, so a slow host may sample it late
  always @(posedge clk) begin
    if (srst) begin
      rdata <= `READ_ZERO;
    end else if (rd_take) begin
      rdata <= rdata_nxt;
    end
  end

  // One-cycle pulse in the cycle after the read is taken
  always @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= rd_en;
    end
  end

  // ----------------------------------------
  // Channel switches
  // ----------------------------------------
  // Registered so the analog side never sees decode glitches; costs a cycle
  always @(posedge clk) begin
    if (srst) begin
      chan_on <= `CH_BUS_RESET;
      shutdown_pulldown_en <= `CH_BUS_RESET;
      low_quiescent_mode <= `CH_BUS_RESET;
    end else if (ce) begin
      chan_on <= on_w;
      shutdown_pulldown_en <= pd_w;
      low_quiescent_mode <= lq_w;
    end
  end

  // ----------------------------------------
  // Channel settings
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      turn_on_delay <= `DELAY_BUS_RESET;
      output_level_code <= `LEVEL_BUS_RESET;
    end else if (ce) begin
      turn_on_delay <= dly_w;
      // Channel a has no level register here; its slot is dropped
      output_level_code <= level_all[`LEVEL_ALL_HI:`LEVEL_ALL_LO];
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // A level, not a latch: it drops three clocks after the fault clears (two synchronizer flops, then this register)
  assign irq_any = |irq_w;
  always @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_any;
    end
  end

endmodule

// ===== ldo_host_model.sv
/* Host model issuing register writes and reads.
   Assumes strobes are sampled at the rising clock edge. */
`timescale 1ns/1ps
module ldo_host_model (
  input wire clk,
  output logic ce,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial {ce, wr_en, rd_en, addr, wdata} = {1'b1, 1'b0, 1'b0, 8'h00, 8'h00};
  // Released lines show the inverse so a stale value never reads back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge clk) {addr, wdata, wr_en} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) {addr, rd_en} <= {a, 1'b1};
    @(posedge clk) {addr, rd_en} <= {~a, 1'b0};
  endtask
  // A write while the clock enable is low must leave every field alone
  task automatic stall_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) ce <= 1'b0;
    wr(a, d);
    @(posedge clk) ce <= 1'b1;
  endtask
endmodule

// ===== test_ldo_control_registers.sv
/* Self-checking bench for the regulator bank.
   Assumes the host model drives the bus. */
`timescale 1ns/1ps
module test_ldo_control_registers;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] pgood_in = 4'h0, fault_in = 4'h0;
  wire ce, wr_en, rd_en, rvalid, irq;
  wire [7:0] addr, wdata, rdata;
  wire [3:0] on, pd, lq;
  wire [11:0] dly;
  wire [17:0] lvl;
  logic [7:0] d, mc [4] = '{default: 8'h00}, ml [4] = '{default: 8'h00}, q [$];
  logic [7:0] ca [4] = '{8'h51, 8'h55, 8'h61, 8'h65}, la [4] = '{8'h50, 8'h54, 8'h60, 8'h64};
  int fail_count = 0, check_count = 0;
  initial forever #50 clk = ~clk;
  ldo_host_model ldo_host_model_i (.clk(clk), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));
  ldo_control_registers ldo_control_registers_i (.clk(clk), .srst(srst), .ce(ce),
    .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
    .pgood_in(pgood_in), .fault_in(fault_in), .chan_on(on), .shutdown_pulldown_en(pd),
    .low_quiescent_mode(lq), .turn_on_delay(dly), .output_level_code(lvl), .irq(irq));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_fields(input logic [42:0] got, input logic [42:0] exp);
    chk(got, exp);
  endtask
  always @(posedge clk) if (rvalid === 1'b1) chk(rdata, q.size() ? q.pop_front() : 'x);
  task automatic verify;
    logic [42:0] e;
    e = '0;
    repeat (4) @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      e[c] = mc[c][7];
      e[4 + c] = mc[c][6] & ~mc[c][7];
      e[8 + c] = mc[c][5];
      e[12 + 3 * c +: 3] = mc[c][4:2];
      e[24] |= fault_in[c] & mc[c][1];
      if (c > 0) e[19 + 6 * c +: 6] = ml[c][5:0];
      q.push_back(mc[c] | pgood_in[c]);
      ldo_host_model_i.rd(ca[c]);
      q.push_back(ml[c]);
      ldo_host_model_i.rd(la[c]);
    end
    q.push_back(8'h00);
    ldo_host_model_i.rd(8'h70);
    chk_fields({lvl, irq, dly, lq, pd, on}, e);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    final_report;
  end
  initial begin
    void'($urandom(32'h7F06));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    verify;
    for (int r = 0; r < 6; r++) begin
      {pgood_in, fault_in} <= 8'($urandom);
      for (int c = 0; c < 4; c++) begin
        d = 8'($urandom);
        ldo_host_model_i.wr(ca[c], d);
        mc[c] = d & 8'hFE;
        d = 8'($urandom);
        ldo_host_model_i.wr(la[c], d);
        ml[c] = (c > 0) ? d & 8'h3F : 8'h00;
      end
      ldo_host_model_i.wr(8'h70, 8'hFF);
      ldo_host_model_i.stall_wr(ca[r % 4], ~mc[r % 4]);
      verify;
      $display("round %0d done", r);
    end
    repeat (4) @(posedge clk);
    chk(q.size(), 0);
    final_report;
  end
endmodule
